// ===== design/cit_defs.svh
// Purpose: offsets, field positions, reset values and counts for the
//          core interrupt and timer option block
// Assumes: register indexes are word indexes; byte address is four times the index
// Notes:   included by the prescaler and by the core design file
`ifndef CIT_DEFS_SVH
`define CIT_DEFS_SVH

// ----------------------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------------------
`define CIT_IDX_ICR 10'h00b
`define CIT_IDX_ICR_B1 10'h08b
`define CIT_IDX_ICR_B2 10'h10b
`define CIT_IDX_ICR_B3 10'h18b
`define CIT_IDX_OPT 10'h081
`define CIT_IDX_STS 10'h020
`define CIT_IDX_MSK 10'h021

// ----------------------------------------------------------------------------
// interrupt control register fields
// ----------------------------------------------------------------------------
`define CIT_ICR_GLB_EN 7
`define CIT_ICR_PER_EN 6
`define CIT_ICR_TOIE 5
`define CIT_ICR_INTE 4
`define CIT_ICR_PORT_EN 3
`define CIT_ICR_TOIF 2
`define CIT_ICR_EXT_FLG 1
`define CIT_ICR_PORT_FLG 0
`define CIT_ICR_RESET 8'h00

// ----------------------------------------------------------------------------
// timer option register fields
// ----------------------------------------------------------------------------
`define CIT_OPT_PUD 7
`define CIT_OPT_EDGE 6
`define CIT_OPT_CSRC 5
`define CIT_OPT_SEDGE 4
`define CIT_OPT_PASG 3
`define CIT_OPT_RATIO_MSB 2
`define CIT_OPT_RATIO_LSB 0
`define CIT_OPT_RESET 8'hff

// ----------------------------------------------------------------------------
// event status / mask fields
// ----------------------------------------------------------------------------
`define CIT_EV_TOF 0
`define CIT_EV_EXT 1
`define CIT_EV_PORT 2
`define CIT_EV_W 3
`define CIT_STS_RESET 3'h0
`define CIT_MSK_RESET 3'h0

// ----------------------------------------------------------------------------
// synchroniser lanes: ext pin, timer clock pin, four upper nibble pins
// ----------------------------------------------------------------------------
`define CIT_SYNC_W 6
`define CIT_LANE_EXT 0
`define CIT_LANE_TCK 1
`define CIT_LANE_NIB 2

`endif

// ===== design/cit_pkg.sv
// Purpose: shared types of the core interrupt and timer option block
// Assumes: constants live in cit_defs.svh
// Notes:   types only
package cit_pkg;
    typedef logic [7:0] cit_byte_t;
    typedef logic [2:0] cit_ratio_t;
    typedef logic [31:0] cit_word_t;
endpackage

// ===== design/cit_presc_if.sv
// Purpose: carrier between the option logic and the shared prescaler
// Assumes: single clock domain
// Notes:   events are one-cycle pulses
`timescale 1ns/1ps
interface cit_presc_if;
    import cit_pkg::*;
    logic src_evt;
    logic wdt_evt;
    logic assign_wdt;
    cit_ratio_t ratio;
    logic timer_inc;
    logic wdt_tick;
    modport ctrl (output src_evt, output wdt_evt, output assign_wdt, output ratio,
                  input timer_inc, input wdt_tick);
    modport presc (input src_evt, input wdt_evt, input assign_wdt, input ratio,
                   output timer_inc, output wdt_tick);
endinterface

// ===== design/cit_prescaler.sv
// Purpose: single prescaler shared between timer and watchdog
// Assumes: events arrive as one-cycle pulses on CLK
// Notes:   counter restarts whenever the assignment or ratio changes
`timescale 1ns/1ps
`include "cit_defs.svh"
module cit_prescaler (
    input wire logic CLK, // instruction clock
    input wire logic RST_B, // async reset, active low
    cit_presc_if.presc p // prescaler carrier
);
    import cit_pkg::*;

    cit_byte_t cnt_q, cnt_d;
    cit_byte_t lim;
    logic evt;
    logic assign_q, timer_inc_q, timer_inc_d, wdt_tick_q, wdt_tick_d;
    cit_ratio_t ratio_q;

    // last count before a tick: timer divides by 2..256, watchdog by 1..128
    always_comb
    begin
        if (p.assign_wdt)
            lim = cit_byte_t'((9'h001 << p.ratio) - 9'h001);
        else
            lim = cit_byte_t'((9'h002 << p.ratio) - 9'h001);
    end

    // only the assigned side runs through the counter, the other passes straight
    always_comb
    begin
        evt = p.assign_wdt ? p.wdt_evt : p.src_evt;
        cnt_d = cnt_q;
        timer_inc_d = 1'b0;
        wdt_tick_d = 1'b0;
        if (p.assign_wdt)
            timer_inc_d = p.src_evt;
        else
            wdt_tick_d = p.wdt_evt;
        if (p.assign_wdt != assign_q || p.ratio != ratio_q)
            cnt_d = 8'h00;
        else if (evt)
        begin
            if (cnt_q >= lim)
            begin
                cnt_d = 8'h00;
                timer_inc_d = timer_inc_d | !p.assign_wdt;
                wdt_tick_d = wdt_tick_d | p.assign_wdt;
            end
            else
                cnt_d = cit_byte_t'(cnt_q + 8'h01);
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cnt_q <= 8'h00;
            assign_q <= 1'b0;
            ratio_q <= 3'h0;
            timer_inc_q <= 1'b0;
            wdt_tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            assign_q <= p.assign_wdt;
            ratio_q <= p.ratio;
            timer_inc_q <= timer_inc_d;
            wdt_tick_q <= wdt_tick_d;
        end
    end

    assign p.timer_inc = timer_inc_q;
    assign p.wdt_tick = wdt_tick_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_presc_bypass: assert property (@(posedge CLK) disable iff (!RST_B)
        p.assign_wdt && $stable(p.assign_wdt) && p.src_evt |=> p.timer_inc)
        else $error("timer event not passed through while prescaler on watchdog");
    chk_ratio_tick: assert property (@(posedge CLK) disable iff (!RST_B)
        !p.assign_wdt && $stable(p.assign_wdt) && $stable(p.ratio) && p.src_evt
        && cnt_q == cit_byte_t'((9'h002 << p.ratio) - 9'h001) |=> p.timer_inc)
        else $error("timer tick missing at prescale limit");
    cov_wdt_tick: cover property (@(posedge CLK) disable iff (!RST_B) p.wdt_tick);
endmodule

// ===== design/cit_core_irq_opt.sv
// Purpose: core interrupt control and timer option registers behind APB
// Assumes: CLK is the instruction clock; pins are asynchronous to it
// Notes:   zero wait state slave; read data captured in the setup cycle
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "cit_defs.svh"

// Behaviour
// - pull-up disable bit forces all pull-ups off
// - edge bit picks rising or falling external edge
// - clock-source bit picks pin or instruction clock
// - source-edge bit picks falling or rising pin edge
// - shared prescaler goes to watchdog or timer
// - ratio field sets power-of-two division
// - flags set regardless of any enable bit
// - global enable gates every source of the core request, not the IRQ output
// - enable and flag for three sources
// - control register read/write, mirrored at four banks
// - peripheral enable needed for peripheral interrupts
module cit_core_irq_opt (
    input wire logic CLK, // instruction clock, 10 MHz
    input wire logic RST_B, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire cit_pkg::cit_word_t PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic EXT_IRQ_PIN, // external interrupt pin
    input wire logic TIMER_EXT_CLOCK_PIN, // timer external clock pin
    input wire logic [3:0] UPPER_NIBBLE_PINS, // upper nibble of upper port
    input wire logic UPPER_PORT_READ, // pulse: core reads upper port
    input wire logic [7:0] UPPER_PORT_PULL_REQ, // per-pin pull-up from port latch
    input wire logic TIMER_OVERFLOW, // pulse: timer counter overflowed
    input wire logic WDT_EVENT, // pulse: watchdog oscillator tick
    input wire logic PERIPH_IRQ, // any enabled peripheral flag set
    output logic [7:0] UPPER_PORT_PULLUP_EN, // weak pull-up enables
    output logic TIMER_INC, // pulse: increment timer counter
    output logic WDT_TICK, // pulse: prescaled watchdog tick
    output logic CORE_IRQ, // interrupt request to the core
    output logic IRQ // level: unmasked event status set
);
    import cit_pkg::*;

    cit_presc_if pif ();

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [`CIT_SYNC_W-1:0] raw, s1_q, s2_q, s3_q, stab_q, stab_d, prev_q;

    assign raw = {UPPER_NIBBLE_PINS, TIMER_EXT_CLOCK_PIN, EXT_IRQ_PIN};

    // a change is believed once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < `CIT_SYNC_W; gi++)
        begin : g_sync
            assign stab_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : stab_q[gi];
        end
    endgenerate

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d;
            prev_q <= stab_q;
        end
    end

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    logic [9:0] idx;
    logic setup, acc_wr, acc_rd, hit_icr, hit_opt, hit_sts, hit_msk, mapped;

    assign idx = PADDR[11:2];
    // the control register answers in every bank
    assign hit_icr = idx == `CIT_IDX_ICR || idx == `CIT_IDX_ICR_B1
        || idx == `CIT_IDX_ICR_B2 || idx == `CIT_IDX_ICR_B3;
    assign hit_opt = idx == `CIT_IDX_OPT;
    assign hit_sts = idx == `CIT_IDX_STS;
    assign hit_msk = idx == `CIT_IDX_MSK;
    assign mapped = (hit_icr || hit_opt || hit_sts || hit_msk) && PADDR[1:0] == 2'b00;
    assign setup = PSEL && !PENABLE;
    assign acc_wr = PSEL && PENABLE && PWRITE && mapped;
    assign acc_rd = PSEL && PENABLE && !PWRITE && mapped;

    // ------------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------------
    cit_byte_t icr_q, icr_d, opt_q, opt_d;
    logic [3:0] port_latch_q, port_latch_d;
    logic ext_evt, tck_rise, tck_fall, port_mismatch;
    logic [`CIT_EV_W-1:0] ev;

    assign ext_evt = opt_q[`CIT_OPT_EDGE]
        ? (stab_q[`CIT_LANE_EXT] && !prev_q[`CIT_LANE_EXT])
        : (!stab_q[`CIT_LANE_EXT] && prev_q[`CIT_LANE_EXT]);
    assign tck_rise = stab_q[`CIT_LANE_TCK] && !prev_q[`CIT_LANE_TCK];
    assign tck_fall = !stab_q[`CIT_LANE_TCK] && prev_q[`CIT_LANE_TCK];
    assign port_mismatch = stab_q[`CIT_LANE_NIB +: 4] != port_latch_q;
    assign ev = {port_mismatch, ext_evt, TIMER_OVERFLOW};

    // a port read snapshots the pins, ending the mismatch
    always_comb
    begin
        port_latch_d = UPPER_PORT_READ ? stab_q[`CIT_LANE_NIB +: 4] : port_latch_q;
    end

    // ------------------------------------------------------------------------
    // prescaler hookup
    // ------------------------------------------------------------------------
    assign pif.src_evt = opt_q[`CIT_OPT_CSRC]
        ? (opt_q[`CIT_OPT_SEDGE] ? tck_fall : tck_rise)
        : 1'b1;
    assign pif.wdt_evt = WDT_EVENT;
    assign pif.assign_wdt = opt_q[`CIT_OPT_PASG];
    assign pif.ratio = opt_q[`CIT_OPT_RATIO_MSB:`CIT_OPT_RATIO_LSB];

    cit_prescaler u_presc (
        .CLK(CLK),
        .RST_B(RST_B),
        .p(pif.presc)
    );

    assign TIMER_INC = pif.timer_inc;
    assign WDT_TICK = pif.wdt_tick;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [`CIT_EV_W-1:0] sts_q, sts_d, msk_q, msk_d, rd_clr;
    logic [31:0] prdata_q, prdata_d;
    logic err_q, err_d, core_irq_q, core_irq_d, irq_q, irq_d;
    cit_byte_t pull_q, pull_d;

    // flags: set wins over a software write of zero; hardware never clears
    always_comb
    begin
        icr_d = icr_q;
        opt_d = opt_q;
        msk_d = msk_q;
        if (acc_wr && hit_icr)
            icr_d = PWDATA[7:0];
        if (acc_wr && hit_opt)
            opt_d = PWDATA[7:0];
        if (acc_wr && hit_msk)
            msk_d = PWDATA[`CIT_EV_W-1:0];
        icr_d[`CIT_ICR_TOIF] = icr_d[`CIT_ICR_TOIF] | ev[`CIT_EV_TOF];
        icr_d[`CIT_ICR_EXT_FLG] = icr_d[`CIT_ICR_EXT_FLG] | ev[`CIT_EV_EXT];
        icr_d[`CIT_ICR_PORT_FLG] = icr_d[`CIT_ICR_PORT_FLG] | ev[`CIT_EV_PORT];
    end

    // the mask gates only the level output, never the status bits themselves
    // status read clears only what the read returned, so a late event survives
    always_comb
    begin
        rd_clr = (acc_rd && hit_sts) ? prdata_q[`CIT_EV_W-1:0] : '0;
        sts_d = (sts_q & ~rd_clr) | ev;
        irq_d = |(sts_d & msk_d);
    end

    // read data and error are captured in the setup cycle, held through access
    always_comb
    begin
        prdata_d = prdata_q;
        err_d = err_q;
        if (setup)
        begin
            err_d = !mapped;
            prdata_d = '0;
            if (!PWRITE && mapped)
            begin
                if (hit_icr)
                    prdata_d[7:0] = icr_d;
                else if (hit_opt)
                    prdata_d[7:0] = opt_d;
                else if (hit_sts)
                    prdata_d[`CIT_EV_W-1:0] = sts_d;
                else
                    prdata_d[`CIT_EV_W-1:0] = msk_d;
            end
        end
    end

    // core request: global gate over the three sources and the peripheral group
    always_comb
    begin
        core_irq_d = icr_q[`CIT_ICR_GLB_EN] && (
            (icr_q[`CIT_ICR_TOIE] && icr_q[`CIT_ICR_TOIF]) ||
            (icr_q[`CIT_ICR_INTE] && icr_q[`CIT_ICR_EXT_FLG]) ||
            (icr_q[`CIT_ICR_PORT_EN] && icr_q[`CIT_ICR_PORT_FLG]) ||
            (icr_q[`CIT_ICR_PER_EN] && PERIPH_IRQ));
        pull_d = opt_q[`CIT_OPT_PUD] ? 8'h00 : UPPER_PORT_PULL_REQ;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            icr_q <= `CIT_ICR_RESET;
            opt_q <= `CIT_OPT_RESET;
            sts_q <= `CIT_STS_RESET;
            msk_q <= `CIT_MSK_RESET;
            port_latch_q <= 4'h0;
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            core_irq_q <= 1'b0;
            irq_q <= 1'b0;
            pull_q <= 8'h00;
        end
        else
        begin
            icr_q <= icr_d;
            opt_q <= opt_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
            port_latch_q <= port_latch_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
            core_irq_q <= core_irq_d;
            irq_q <= irq_d;
            pull_q <= pull_d;
        end
    end

    // bus outputs; pready is tied high, so every access ends in one cycle
    assign PRDATA = prdata_q;
    assign PREADY = 1'b1; // zero wait states
    assign PSLVERR = PSEL && PENABLE && err_q;
    assign CORE_IRQ = core_irq_q;
    assign IRQ = irq_q;
    assign UPPER_PORT_PULLUP_EN = pull_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    // every check runs on CLK and is held off while RST_B is low
    chk_pullup_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        opt_q[`CIT_OPT_PUD] |=> UPPER_PORT_PULLUP_EN == 8'h00)
        else $error("pull-ups on while disabled");
    chk_ext_edge_flag: assert property (@(posedge CLK) disable iff (!RST_B)
        opt_q[`CIT_OPT_EDGE] && $rose(stab_q[`CIT_LANE_EXT]) |=> icr_q[`CIT_ICR_EXT_FLG])
        else $error("rising edge did not set external flag");
    chk_tclk_internal: assert property (@(posedge CLK) disable iff (!RST_B)
        !opt_q[`CIT_OPT_CSRC] |-> pif.src_evt)
        else $error("internal timer clock missing");
    chk_tclk_fall: assert property (@(posedge CLK) disable iff (!RST_B)
        opt_q[`CIT_OPT_CSRC] && opt_q[`CIT_OPT_SEDGE] && $rose(stab_q[`CIT_LANE_TCK])
        |-> !pif.src_evt)
        else $error("timer counted on wrong pin edge");
    chk_flag_indep: assert property (@(posedge CLK) disable iff (!RST_B)
        TIMER_OVERFLOW |=> icr_q[`CIT_ICR_TOIF])
        else $error("overflow flag not set");
    chk_global_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        !icr_q[`CIT_ICR_GLB_EN] |=> !CORE_IRQ)
        else $error("interrupt raised with global enable clear");
    chk_mirror_read: assert property (@(posedge CLK) disable iff (!RST_B)
        setup && !PWRITE && hit_icr && PADDR[1:0] == 2'b00 |=> PRDATA[7:0] == $past(icr_d))
        else $error("control register read wrong in a bank");
    chk_periph_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        icr_q[`CIT_ICR_GLB_EN] && icr_q[`CIT_ICR_PER_EN] && PERIPH_IRQ |=> CORE_IRQ)
        else $error("peripheral interrupt not raised");
    chk_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        icr_q[`CIT_ICR_TOIF] && !(acc_wr && hit_icr) |=> icr_q[`CIT_ICR_TOIF])
        else $error("flag cleared by hardware");
    chk_port_change: assert property (@(posedge CLK) disable iff (!RST_B)
        port_mismatch |=> icr_q[`CIT_ICR_PORT_FLG] ##0 sts_q[`CIT_EV_PORT])
        else $error("port mismatch did not set flag");
    // status and request outputs against the register state
    chk_irq_level: assert property (@(posedge CLK) disable iff (!RST_B)
        IRQ == |(sts_q & msk_q))
        else $error("interrupt output disagrees with status and mask");
    chk_ext_request: assert property (@(posedge CLK) disable iff (!RST_B)
        icr_q[`CIT_ICR_GLB_EN] && icr_q[`CIT_ICR_INTE] && icr_q[`CIT_ICR_EXT_FLG] |=> CORE_IRQ)
        else $error("external interrupt not raised");
    chk_status_clear: assert property (@(posedge CLK) disable iff (!RST_B)
        acc_rd && hit_sts && prdata_q[`CIT_EV_TOF] && !ev[`CIT_EV_TOF] |=> !sts_q[`CIT_EV_TOF])
        else $error("status bit survived its read");

    cov_core_irq: cover property (@(posedge CLK) disable iff (!RST_B) $rose(CORE_IRQ));
    cov_status_clear: cover property (@(posedge CLK) disable iff (!RST_B)
        acc_rd && hit_sts && |sts_q);
    cov_ext_clock: cover property (@(posedge CLK) disable iff (!RST_B)
        opt_q[`CIT_OPT_CSRC] && TIMER_INC);
    cov_port_read: cover property (@(posedge CLK) disable iff (!RST_B)
        port_mismatch && UPPER_PORT_READ);
endmodule

// ===== bench/cit_core_irq_opt_tb_top.sv
// Purpose: self-checking bench for the core interrupt and timer option block
// Assumes: zero wait state apb slave; pins settle through the synchronisers in a few cycles
// Notes:   every scenario is a task; inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module cit_core_irq_opt_tb_top;
    import cit_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    cit_word_t pwdata;
    logic [31:0] prdata, rd;
    logic ext_pin, tck, port_rd, tovf, wdog_ev, periph, tinc, wtick, core_irq, irq;
    logic [3:0] nib;
    logic [7:0] pull_req, pull_en;
    int bad_count, check_count, cyc, tinc_n, wtick_n;

    cit_core_irq_opt cit_core_irq_opt_inst (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PIN(ext_pin), .TIMER_EXT_CLOCK_PIN(tck),
        .UPPER_NIBBLE_PINS(nib), .UPPER_PORT_READ(port_rd), .UPPER_PORT_PULL_REQ(pull_req),
        .TIMER_OVERFLOW(tovf), .WDT_EVENT(wdog_ev), .PERIPH_IRQ(periph),
        .UPPER_PORT_PULLUP_EN(pull_en), .TIMER_INC(tinc), .WDT_TICK(wtick),
        .CORE_IRQ(core_irq), .IRQ(irq));

    // ------------------------------------------------------------------------
    // clock, pulse counters and hang guard
    // ------------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // counted on the falling edge so the registered pulses have settled
    always @(negedge clk)
    begin
        if (tinc === 1'b1) tinc_n++;
        if (wtick === 1'b1) wtick_n++;
    end
    // the whole run needs about 6600 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge clk);
    endtask
    // holds the request until pready is sampled high, then releases it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // if pready never rises, only the hang guard ends this wait
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        rdc(12'h204, 32'hff);
        rdc(12'h02c, 32'h0);
        rdc(12'h080, 32'h0);
        chk(pull_en, 32'h0);
        wr(12'h084, 32'h5);
        rdc(12'h084, 32'h5);
        chk({31'h0, err}, 32'h0);
        wr(12'h084, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 12'h02d, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_mirror();
        wr(12'h22c, 32'h78);
        rdc(12'h02c, 32'h78);
        rdc(12'h42c, 32'h78);
        rdc(12'h62c, 32'h78);
        wr(12'h62c, 32'h0);
        rdc(12'h02c, 32'h0);
    endtask
    // flag rises with every enable off, then the gates are tried one by one
    task automatic t_timer();
        tovf <= 1'b1;
        cw(1);
        tovf <= 1'b0;
        cw(2);
        rdc(12'h02c, 32'h04);
        cw(5);
        rdc(12'h02c, 32'h04);
        wr(12'h02c, 32'h24);
        cw(3);
        chk(core_irq, 32'h0);
        wr(12'h02c, 32'ha4);
        cw(3);
        chk(core_irq, 32'h1);
        wr(12'h02c, 32'h80);
        cw(3);
        chk(core_irq, 32'h0);
        periph <= 1'b1;
        wr(12'h02c, 32'hc0);
        cw(3);
        chk(core_irq, 32'h1);
        wr(12'h02c, 32'h80);
        cw(3);
        chk(core_irq, 32'h0);
        periph <= 1'b0;
        wr(12'h02c, 32'h0);
        wr(12'h02c, 32'ha0);
        cw(3);
        chk(core_irq, 32'h0);
        wr(12'h02c, 32'h0);
        wr(12'h084, 32'h1);
        cw(3);
        chk(irq, 32'h1);
        rdc(12'h080, 32'h1);
        cw(3);
        chk(irq, 32'h0);
        wr(12'h084, 32'h0);
    endtask
    task automatic t_ext();
        wr(12'h204, 32'h48);
        ext_pin <= 1'b1;
        cw(10);
        rdc(12'h02c, 32'h02);
        wr(12'h02c, 32'h0);
        ext_pin <= 1'b0;
        cw(10);
        rdc(12'h02c, 32'h0);
        wr(12'h204, 32'h08);
        ext_pin <= 1'b1;
        cw(10);
        rdc(12'h02c, 32'h0);
        ext_pin <= 1'b0;
        cw(10);
        rdc(12'h02c, 32'h02);
        wr(12'h02c, 32'h0);
        rdc(12'h080, 32'h2);
    endtask
    // a write of zero cannot clear the flag until a port read ends the mismatch
    task automatic t_port();
        nib <= 4'h5;
        cw(10);
        rdc(12'h02c, 32'h01);
        wr(12'h02c, 32'h0);
        cw(2);
        rdc(12'h02c, 32'h01);
        port_rd <= 1'b1;
        cw(1);
        port_rd <= 1'b0;
        cw(2);
        wr(12'h02c, 32'h0);
        cw(3);
        rdc(12'h02c, 32'h0);
        rdc(12'h080, 32'h4);
    endtask
    task automatic t_pull();
        pull_req <= 8'ha5;
        wr(12'h204, 32'h08);
        cw(3);
        chk(pull_en, 32'ha5);
        wr(12'h204, 32'h88);
        cw(3);
        chk(pull_en, 32'h0);
    endtask
    // windows are whole multiples of the period, so the counts are exact
    task automatic t_presc();
        int n, m;
        for (int r = 0; r < 8; r++)
        begin
            wr(12'h204, 32'(r));
            cw(4);
            n = tinc_n;
            cw(512);
            chk(32'(tinc_n - n), 32'(512 >> (r + 1)));
        end
        for (int r = 0; r < 8; r++)
        begin
            wr(12'h204, 32'(8 + r));
            cw(4);
            n = tinc_n;
            m = wtick_n;
            repeat (128)
            begin
                wdog_ev <= 1'b1;
                cw(1);
                wdog_ev <= 1'b0;
                cw(1);
            end
            cw(4);
            chk(32'(wtick_n - m), 32'(128 >> r));
            chk(32'(tinc_n - n), 32'd260);
        end
    endtask
    // odd toggle counts make the rising and falling totals differ
    task automatic t_extclk();
        int n;
        wr(12'h204, 32'h28);
        // the last pulse from the internal clock is still in flight
        cw(2);
        n = tinc_n;
        repeat (5)
        begin
            tck <= ~tck;
            cw(6);
        end
        chk(32'(tinc_n - n), 32'd3);
        wr(12'h204, 32'h38);
        n = tinc_n;
        repeat (3)
        begin
            tck <= ~tck;
            cw(6);
        end
        chk(32'(tinc_n - n), 32'd2);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; ext_pin = 1'b0; tck = 1'b0; nib = 4'h0; port_rd = 1'b0;
        pull_req = 8'h0; tovf = 1'b0; wdog_ev = 1'b0; periph = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_mirror();
        t_timer();
        t_ext();
        t_port();
        t_pull();
        t_presc();
        t_extclk();
        report_and_stop();
    end
endmodule
